// ===== hw/ppfm_params.svh
// constants of the port pin function multiplexer
`ifndef PPFM_PARAMS_SVH
`define PPFM_PARAMS_SVH
// register byte offsets on the avalon slave
`define PPFM_ADDR_W 6
`define PPFM_OFS_P1_DIR 6'h00
`define PPFM_OFS_P1_SEL 6'h04
`define PPFM_OFS_P1_OUT 6'h08
`define PPFM_OFS_P1_IN 6'h0c
`define PPFM_OFS_P2_DIR 6'h10
`define PPFM_OFS_P2_SEL 6'h14
`define PPFM_OFS_P2_OUT 6'h18
`define PPFM_OFS_P2_IN 6'h1c
`define PPFM_OFS_ANALOG 6'h20
`define PPFM_OFS_STATUS 6'h24
// field positions in the port two registers
`define PPFM_P2_PIN_A_BIT 0
`define PPFM_P2_PIN_B_BIT 2
// field positions in the status register
`define PPFM_STAT_TEST_BIT 0
`define PPFM_STAT_FUSE_BIT 1
// reset values
`define PPFM_P1_RST 8'h00
`define PPFM_P2_RST 2'h0
`define PPFM_RDATA_RST 32'h0000_0000
`endif

// ===== hw/ppfm_pkg.sv
// types of the port pin function multiplexer
package ppfm_pkg;
  // one bit per pin: port one pins 7..0, port two pins 2 and 0
  typedef struct packed {
    logic [7:0] one;
    logic [1:0] two;
  } ppfm_pin_s;
  // avalon slave handshake states
  typedef enum logic [1:0] {
    BUS_IDLE = 2'b01,
    BUS_ACK = 2'b10
  } ppfm_bus_state_e;
endpackage

// ===== hw/ppfm_top.sv
// port pin function multiplexer with avalon register slave
//
// Contract
// - select 0 gives gpio, direction picks in/out
// - pin 0 alt: timer clock in, converter clock out
// - pins 1-3 alt: capture in, compare out
// - test mode makes pins 4-6 test inputs
// - pins 4-6 alt outputs outside test mode
// - pin 7 test data, else compare two
// - test logic owns direction in test mode
// - both resets return every pin to gpio outside test mode
// - port two pins 0, 2 alt functions
// - analog enable overrides direction and select
// - analog enable kills driver and schmitt input
// - blown fuse refuses all debug access
// - blown fuse forces permanent test bypass
`timescale 1ns/100ps
`include "ppfm_params.svh"
module ppfm_top (
  input wire logic CORE_CLK_IN,
  input wire logic RESETN_IN,
  input wire logic POWER_UP_CLEAR_IN,
  input wire logic [`PPFM_ADDR_W-1:0] AVS_ADDRESS_IN,
  input wire logic AVS_READ_IN,
  input wire logic AVS_WRITE_IN,
  input wire logic [31:0] AVS_WRITEDATA_IN,
  input wire logic [3:0] AVS_BYTEENABLE_IN,
  output logic [31:0] AVS_READDATA_OUT,
  output logic AVS_WAITREQUEST_OUT,
  input wire logic [7:0] P1_PIN_IN,
  output logic [7:0] P1_PIN_OUT,
  output logic [7:0] P1_PIN_OE_OUT,
  input wire logic [1:0] P2_PIN_IN,
  output logic [1:0] P2_PIN_OUT,
  output logic [1:0] P2_PIN_OE_OUT,
  output logic [1:0] P2_SCHMITT_EN_OUT,
  output logic [1:0] ANALOG_SEL_OUT,
  input wire logic CONVERTER_CLOCK_IN,
  input wire logic SUBSYSTEM_CLOCK_IN,
  input wire logic AUX_CLOCK_IN,
  input wire logic [2:0] TIMER_COMPARE_IN,
  output logic TIMER_EXT_CLOCK_OUT,
  output logic [2:0] TIMER_CAPTURE_A_OUT,
  output logic TIMER_CAPTURE_B_OUT,
  input wire logic TEST_4WIRE_IN,
  input wire logic TEST_TDO_IN,
  input wire logic TEST_TDO_OE_IN,
  output logic TEST_TCK_OUT,
  output logic TEST_TMS_OUT,
  output logic TEST_TDI_OUT,
  output logic TEST_TDI7_OUT,
  input wire logic FUSE_BLOWN_IN,
  output logic DEBUG_ACCESS_EN_OUT,
  output logic TEST_BYPASS_OUT
);

  localparam int SYNC_W = 12; // pins plus test request plus fuse

  // two-flop synchronisers for the pin levels, the test request and the fuse sense
  logic [SYNC_W-1:0] sync_raw;
  logic [SYNC_W-1:0] sync_meta_r; // first stage, read only by the second
  logic [SYNC_W-1:0] sync_r; // safe to use
  assign sync_raw = {FUSE_BLOWN_IN, TEST_4WIRE_IN, P2_PIN_IN, P1_PIN_IN};

  genvar gi;
  generate
    for (gi = 0; gi < SYNC_W; gi++)
    begin : g_sync
      // one synchroniser per input bit
      always_ff @(posedge CORE_CLK_IN or negedge RESETN_IN)
      begin
        if (!RESETN_IN)
        begin
          sync_meta_r[gi] <= 1'b0;
          sync_r[gi] <= 1'b0;
        end
        else
        begin
          sync_meta_r[gi] <= sync_raw[gi];
          sync_r[gi] <= sync_meta_r[gi];
        end
      end
    end
  endgenerate

  logic [7:0] p1_pin; // synchronised port one pin levels
  logic [1:0] p2_pin; // synchronised port two pin levels
  logic test_req; // synchronised 4-wire test request
  logic fuse_pin; // synchronised fuse sense
  assign p1_pin = sync_r[7:0];
  assign p2_pin = sync_r[9:8];
  assign test_req = sync_r[10];
  assign fuse_pin = sync_r[11];

  // configuration state
  logic [7:0] port_one_direction_r, port_one_direction_nxt;
  logic [7:0] port_one_function_select_r, port_one_function_select_nxt;
  logic [7:0] p1_data_r, p1_data_nxt; // port one output data
  logic [1:0] port_two_direction_r, port_two_direction_nxt;
  logic [1:0] port_two_function_select_r, port_two_function_select_nxt;
  logic [1:0] p2_data_r, p2_data_nxt; // port two output data
  logic [1:0] analog_input_enable_r, analog_input_enable_nxt;
  logic fuse_r, fuse_nxt; // sticky once the fuse reads blown
  logic test_mode; // test port owns pins 4..7

  // bus state
  ppfm_pkg::ppfm_bus_state_e bus_r, bus_nxt;
  logic waitreq_r, waitreq_nxt;
  logic [31:0] rdata_r, rdata_nxt;
  logic bus_req; // read or write pending
  logic do_write; // write takes effect this edge
  assign bus_req = AVS_READ_IN | AVS_WRITE_IN;
  assign do_write = AVS_WRITE_IN & (bus_r == ppfm_pkg::BUS_ACK) & AVS_BYTEENABLE_IN[0];

  // fuse lockout wins over any test request
  assign test_mode = test_req & ~fuse_r;

  // next configuration: power-up clear, then bus writes
  always_comb
  begin
    port_one_direction_nxt = port_one_direction_r;
    port_one_function_select_nxt = port_one_function_select_r;
    p1_data_nxt = p1_data_r;
    port_two_direction_nxt = port_two_direction_r;
    port_two_function_select_nxt = port_two_function_select_r;
    p2_data_nxt = p2_data_r;
    analog_input_enable_nxt = analog_input_enable_r;
    // the fuse cannot heal, so only power-on reset clears the latch
    fuse_nxt = fuse_r | fuse_pin;
    if (POWER_UP_CLEAR_IN)
    begin
      // clear returns all pins to gpio input outside test mode
      port_one_direction_nxt = `PPFM_P1_RST;
      port_one_function_select_nxt = `PPFM_P1_RST;
      p1_data_nxt = `PPFM_P1_RST;
      port_two_direction_nxt = `PPFM_P2_RST;
      port_two_function_select_nxt = `PPFM_P2_RST;
      p2_data_nxt = `PPFM_P2_RST;
      analog_input_enable_nxt = `PPFM_P2_RST;
    end
    else if (do_write)
    begin
      // address decode, unmapped and read-only offsets ignore writes
      if (AVS_ADDRESS_IN == `PPFM_OFS_P1_DIR)
        port_one_direction_nxt = AVS_WRITEDATA_IN[7:0];
      else if (AVS_ADDRESS_IN == `PPFM_OFS_P1_SEL)
        port_one_function_select_nxt = AVS_WRITEDATA_IN[7:0];
      else if (AVS_ADDRESS_IN == `PPFM_OFS_P1_OUT)
        p1_data_nxt = AVS_WRITEDATA_IN[7:0];
      else if (AVS_ADDRESS_IN == `PPFM_OFS_P2_DIR)
        port_two_direction_nxt = {AVS_WRITEDATA_IN[`PPFM_P2_PIN_B_BIT],
                                  AVS_WRITEDATA_IN[`PPFM_P2_PIN_A_BIT]};
      else if (AVS_ADDRESS_IN == `PPFM_OFS_P2_SEL)
        port_two_function_select_nxt = {AVS_WRITEDATA_IN[`PPFM_P2_PIN_B_BIT],
                                        AVS_WRITEDATA_IN[`PPFM_P2_PIN_A_BIT]};
      else if (AVS_ADDRESS_IN == `PPFM_OFS_P2_OUT)
        p2_data_nxt = {AVS_WRITEDATA_IN[`PPFM_P2_PIN_B_BIT],
                       AVS_WRITEDATA_IN[`PPFM_P2_PIN_A_BIT]};
      else if (AVS_ADDRESS_IN == `PPFM_OFS_ANALOG)
        analog_input_enable_nxt = {AVS_WRITEDATA_IN[`PPFM_P2_PIN_B_BIT],
                                   AVS_WRITEDATA_IN[`PPFM_P2_PIN_A_BIT]};
    end
  end

  // configuration registers
  always_ff @(posedge CORE_CLK_IN or negedge RESETN_IN)
  begin
    if (!RESETN_IN)
    begin
      port_one_direction_r <= `PPFM_P1_RST;
      port_one_function_select_r <= `PPFM_P1_RST;
      p1_data_r <= `PPFM_P1_RST;
      port_two_direction_r <= `PPFM_P2_RST;
      port_two_function_select_r <= `PPFM_P2_RST;
      p2_data_r <= `PPFM_P2_RST;
      analog_input_enable_r <= `PPFM_P2_RST;
      fuse_r <= 1'b0;
    end
    else
    begin
      port_one_direction_r <= port_one_direction_nxt;
      port_one_function_select_r <= port_one_function_select_nxt;
      p1_data_r <= p1_data_nxt;
      port_two_direction_r <= port_two_direction_nxt;
      port_two_function_select_r <= port_two_function_select_nxt;
      p2_data_r <= p2_data_nxt;
      analog_input_enable_r <= analog_input_enable_nxt;
      fuse_r <= fuse_nxt;
    end
  end

  // avalon slave: one wait cycle, then a single ack cycle
  always_comb
  begin
    bus_nxt = bus_r;
    rdata_nxt = rdata_r;
    case (bus_r)
      ppfm_pkg::BUS_IDLE:
      begin
        if (bus_req)
        begin
          bus_nxt = ppfm_pkg::BUS_ACK;
          rdata_nxt = `PPFM_RDATA_RST; // unmapped reads return zero
          if (AVS_ADDRESS_IN == `PPFM_OFS_P1_DIR)
            rdata_nxt[7:0] = port_one_direction_r;
          else if (AVS_ADDRESS_IN == `PPFM_OFS_P1_SEL)
            rdata_nxt[7:0] = port_one_function_select_r;
          else if (AVS_ADDRESS_IN == `PPFM_OFS_P1_OUT)
            rdata_nxt[7:0] = p1_data_r;
          else if (AVS_ADDRESS_IN == `PPFM_OFS_P1_IN)
            rdata_nxt[7:0] = p1_pin;
          else if (AVS_ADDRESS_IN == `PPFM_OFS_P2_DIR)
          begin
            rdata_nxt[`PPFM_P2_PIN_A_BIT] = port_two_direction_r[0];
            rdata_nxt[`PPFM_P2_PIN_B_BIT] = port_two_direction_r[1];
          end
          else if (AVS_ADDRESS_IN == `PPFM_OFS_P2_SEL)
          begin
            rdata_nxt[`PPFM_P2_PIN_A_BIT] = port_two_function_select_r[0];
            rdata_nxt[`PPFM_P2_PIN_B_BIT] = port_two_function_select_r[1];
          end
          else if (AVS_ADDRESS_IN == `PPFM_OFS_P2_OUT)
          begin
            rdata_nxt[`PPFM_P2_PIN_A_BIT] = p2_data_r[0];
            rdata_nxt[`PPFM_P2_PIN_B_BIT] = p2_data_r[1];
          end
          else if (AVS_ADDRESS_IN == `PPFM_OFS_P2_IN)
          begin
            // schmitt trigger off on analog pins, so they read low
            rdata_nxt[`PPFM_P2_PIN_A_BIT] = p2_pin[0] & ~analog_input_enable_r[0];
            rdata_nxt[`PPFM_P2_PIN_B_BIT] = p2_pin[1] & ~analog_input_enable_r[1];
          end
          else if (AVS_ADDRESS_IN == `PPFM_OFS_ANALOG)
          begin
            rdata_nxt[`PPFM_P2_PIN_A_BIT] = analog_input_enable_r[0];
            rdata_nxt[`PPFM_P2_PIN_B_BIT] = analog_input_enable_r[1];
          end
          else if (AVS_ADDRESS_IN == `PPFM_OFS_STATUS)
          begin
            rdata_nxt[`PPFM_STAT_TEST_BIT] = test_mode;
            rdata_nxt[`PPFM_STAT_FUSE_BIT] = fuse_r;
          end
        end
      end
      ppfm_pkg::BUS_ACK:
        bus_nxt = ppfm_pkg::BUS_IDLE;
      default:
        bus_nxt = ppfm_pkg::BUS_IDLE;
    endcase
    waitreq_nxt = (bus_nxt != ppfm_pkg::BUS_ACK);
  end

  // bus registers, waitrequest idles high
  always_ff @(posedge CORE_CLK_IN or negedge RESETN_IN)
  begin
    if (!RESETN_IN)
    begin
      bus_r <= ppfm_pkg::BUS_IDLE;
      waitreq_r <= 1'b1;
      rdata_r <= `PPFM_RDATA_RST;
    end
    else
    begin
      bus_r <= bus_nxt;
      waitreq_r <= waitreq_nxt;
      rdata_r <= rdata_nxt;
    end
  end
  assign AVS_READDATA_OUT = rdata_r;
  assign AVS_WAITREQUEST_OUT = waitreq_r;

  // pin multiplexer next values
  ppfm_pkg::ppfm_pin_s do_nxt, do_r; // pin drive levels
  ppfm_pkg::ppfm_pin_s oe_nxt, oe_r; // pin output enables
  logic [7:0] p1_alt; // alternate output per port one pin
  logic [7:0] p1_in_fn; // pin selected to an input function
  logic [1:0] p2_alt;
  logic [1:0] schmitt_nxt, schmitt_r;
  logic [1:0] ana_r; // analog select, its own flop so the pin comes straight from a register
  logic [11:0] per_nxt, per_r; // peripheral and test-side outputs
  assign p1_alt = {TIMER_COMPARE_IN, SUBSYSTEM_CLOCK_IN, TIMER_COMPARE_IN,
                   CONVERTER_CLOCK_IN};
  assign p2_alt = {TIMER_COMPARE_IN[0], AUX_CLOCK_IN};
  assign p1_in_fn = port_one_function_select_r & ~port_one_direction_r;

  always_comb
  begin
    // select picks the source, direction the driver
    do_nxt.one = port_one_function_select_r & p1_alt
               | ~port_one_function_select_r & p1_data_r;
    oe_nxt.one = port_one_direction_r;
    if (test_mode)
    begin
      // test logic owns pins 4..7, port bits are ignored
      oe_nxt.one[6:4] = 3'h0;
      do_nxt.one[7] = TEST_TDO_IN;
      oe_nxt.one[7] = TEST_TDO_OE_IN;
    end
    // analog enable overrides select and direction
    do_nxt.two = port_two_function_select_r & p2_alt
               | ~port_two_function_select_r & p2_data_r;
    oe_nxt.two = port_two_direction_r & ~analog_input_enable_r;
    schmitt_nxt = ~analog_input_enable_r;
    per_nxt = 12'h000;
    per_nxt[0] = p1_in_fn[0] & p1_pin[0];
    per_nxt[3:1] = p1_in_fn[3:1] & p1_pin[3:1];
    per_nxt[4] = port_two_function_select_r[1] & ~port_two_direction_r[1]
               & ~analog_input_enable_r[1] & p2_pin[1];
    per_nxt[8:5] = {4{test_mode}} & p1_pin[7:4];
    per_nxt[9] = ~fuse_r;
    per_nxt[10] = fuse_r;
    per_nxt[11] = 1'b0;
  end

  // pin and peripheral output registers
  always_ff @(posedge CORE_CLK_IN or negedge RESETN_IN)
  begin
    if (!RESETN_IN)
    begin
      do_r <= '0;
      oe_r <= '0;
      schmitt_r <= 2'h3;
      ana_r <= 2'h0;
      per_r <= 12'h200; // debug access open until the fuse reads blown
    end
    else
    begin
      do_r <= do_nxt;
      oe_r <= oe_nxt;
      schmitt_r <= schmitt_nxt;
      ana_r <= ~schmitt_nxt;
      per_r <= per_nxt;
    end
  end
  assign P1_PIN_OUT = do_r.one;
  assign P1_PIN_OE_OUT = oe_r.one;
  assign P2_PIN_OUT = do_r.two;
  assign P2_PIN_OE_OUT = oe_r.two;
  assign P2_SCHMITT_EN_OUT = schmitt_r;
  assign ANALOG_SEL_OUT = ana_r;
  assign TIMER_EXT_CLOCK_OUT = per_r[0];
  assign TIMER_CAPTURE_A_OUT = per_r[3:1];
  assign TIMER_CAPTURE_B_OUT = per_r[4];
  assign TEST_TCK_OUT = per_r[5];
  assign TEST_TMS_OUT = per_r[6];
  assign TEST_TDI_OUT = per_r[7];
  assign TEST_TDI7_OUT = per_r[8];
  assign DEBUG_ACCESS_EN_OUT = per_r[9];
  assign TEST_BYPASS_OUT = per_r[10];

  // checks on the registered pin side
  default clocking cb @(posedge CORE_CLK_IN); endclocking
  default disable iff (!RESETN_IN);

  property p_gpio_out;
    (!port_one_function_select_r[2] && port_one_direction_r[2])
      |=> P1_PIN_OE_OUT[2] && (P1_PIN_OUT[2] == $past(p1_data_r[2]));
  endproperty
  a_gpio_out: assert property (p_gpio_out) else $error("gpio output wrong");
  property p_pin0_clk;
    (port_one_function_select_r[0] && port_one_direction_r[0])
      |=> P1_PIN_OUT[0] == $past(CONVERTER_CLOCK_IN);
  endproperty
  a_pin0_clk: assert property (p_pin0_clk) else $error("converter clock lost");
  property p_capture;
    (port_one_function_select_r[1] && !port_one_direction_r[1])
      |=> !P1_PIN_OE_OUT[1] && (TIMER_CAPTURE_A_OUT[0] == $past(p1_pin[1]));
  endproperty
  a_capture: assert property (p_capture) else $error("capture path wrong");
  property p_test_in;
    test_mode |=> (P1_PIN_OE_OUT[6:4] == 3'h0) && (TEST_TMS_OUT == $past(p1_pin[5]));
  endproperty
  a_test_in: assert property (p_test_in) else $error("test inputs driven");
  property p_fuse_prio;
    (fuse_r && port_one_function_select_r[4] && port_one_direction_r[4])
      |=> P1_PIN_OE_OUT[4] && (P1_PIN_OUT[4] == $past(SUBSYSTEM_CLOCK_IN));
  endproperty
  a_fuse_prio: assert property (p_fuse_prio) else $error("fuse lockout lost");
  property p_tdo;
    test_mode |=> (P1_PIN_OUT[7] == $past(TEST_TDO_IN))
              && (P1_PIN_OE_OUT[7] == $past(TEST_TDO_OE_IN));
  endproperty
  a_tdo: assert property (p_tdo) else $error("test data pin wrong");
  sequence s_clear;
    POWER_UP_CLEAR_IN && !test_mode;
  endsequence
  sequence s_gpio_in;
    (port_one_function_select_r == 8'h00) && (port_one_direction_r == 8'h00)
      ##1 (P1_PIN_OE_OUT == 8'h00);
  endsequence
  property p_clear;
    s_clear ##1 !test_mode |-> s_gpio_in;
  endproperty
  a_clear: assert property (p_clear) else $error("clear left a function on");
  property p_analog;
    analog_input_enable_r[1]
      |=> !P2_PIN_OE_OUT[1] && !P2_SCHMITT_EN_OUT[1] && !TIMER_CAPTURE_B_OUT;
  endproperty
  a_analog: assert property (p_analog) else $error("analog pin still driven");
  property p_aux;
    (port_two_function_select_r[0] && port_two_direction_r[0] && !analog_input_enable_r[0])
      |=> P2_PIN_OE_OUT[0] && (P2_PIN_OUT[0] == $past(AUX_CLOCK_IN));
  endproperty
  a_aux: assert property (p_aux) else $error("aux clock lost");
  property p_lock;
    fuse_r |=> (!DEBUG_ACCESS_EN_OUT && !TEST_TCK_OUT && TEST_BYPASS_OUT) [*3];
  endproperty
  a_lock: assert property (p_lock) else $error("debug open after fuse");
endmodule

// ===== verification/ppfm_pad_model.sv
// pad side model: outside sources and the pads shared with the multiplexer
`timescale 1ns/100ps
module ppfm_pad_model (
  input wire logic [7:0] p1_drv_in, // level the multiplexer puts out
  input wire logic [7:0] p1_oe_in, // 1 while the multiplexer drives
  input wire logic [7:0] p1_ext_in, // level of the outside source
  input wire logic [1:0] p2_drv_in,
  input wire logic [1:0] p2_oe_in,
  input wire logic [1:0] p2_ext_in,
  output logic [7:0] p1_pad_out,
  output logic [1:0] p2_pad_out
);
  // each pad carries the multiplexer's level while enabled, else the outside source;
  // the outside source never lets go, so no pad floats to a simulator-chosen level
  always_comb
  begin
    p1_pad_out = (p1_oe_in & p1_drv_in) | (~p1_oe_in & p1_ext_in);
    p2_pad_out = (p2_oe_in & p2_drv_in) | (~p2_oe_in & p2_ext_in);
  end
endmodule

// ===== verification/test_port_pin_function_mux.sv
// self-checking bench for the port pin function multiplexer
`timescale 1ns/100ps
`include "ppfm_params.svh"
module test_port_pin_function_mux;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic power_up_clear = 1'b0;
  logic [5:0] addr = 6'h00;
  logic rd = 1'b0;
  logic wr = 1'b0;
  logic [31:0] wdata = 32'h0;
  logic [3:0] be = 4'hf;
  logic [31:0] rdata;
  logic waitreq;
  logic [7:0] p1_in, p1_out, p1_oe;
  logic [7:0] p1_ext = 8'h00; // outside source levels
  logic [1:0] p2_in, p2_out, p2_oe, p2_sch, p2_ana;
  logic [1:0] p2_ext = 2'h0;
  logic conv = 1'b0, sub = 1'b0, aux = 1'b0;
  logic [2:0] cmp = 3'h0;
  logic ext_clk, cap_b, tck, tms, tdi, tdi7, dbg_en, bypass;
  logic [2:0] cap_a;
  logic test = 1'b0, tdo = 1'b0, tdo_oe = 1'b0, fuse = 1'b0;
  int fail_count = 0;
  int total_checks = 0;
  // free-running core clock, 5 ns period
  always #2.5 clk = ~clk;
  ppfm_top dut (.CORE_CLK_IN(clk), .RESETN_IN(rst_n), .POWER_UP_CLEAR_IN(power_up_clear),
    .AVS_ADDRESS_IN(addr), .AVS_READ_IN(rd), .AVS_WRITE_IN(wr), .AVS_WRITEDATA_IN(wdata),
    .AVS_BYTEENABLE_IN(be), .AVS_READDATA_OUT(rdata), .AVS_WAITREQUEST_OUT(waitreq),
    .P1_PIN_IN(p1_in), .P1_PIN_OUT(p1_out), .P1_PIN_OE_OUT(p1_oe), .P2_PIN_IN(p2_in),
    .P2_PIN_OUT(p2_out), .P2_PIN_OE_OUT(p2_oe), .P2_SCHMITT_EN_OUT(p2_sch),
    .ANALOG_SEL_OUT(p2_ana), .CONVERTER_CLOCK_IN(conv), .SUBSYSTEM_CLOCK_IN(sub),
    .AUX_CLOCK_IN(aux), .TIMER_COMPARE_IN(cmp), .TIMER_EXT_CLOCK_OUT(ext_clk),
    .TIMER_CAPTURE_A_OUT(cap_a), .TIMER_CAPTURE_B_OUT(cap_b), .TEST_4WIRE_IN(test),
    .TEST_TDO_IN(tdo), .TEST_TDO_OE_IN(tdo_oe), .TEST_TCK_OUT(tck), .TEST_TMS_OUT(tms),
    .TEST_TDI_OUT(tdi), .TEST_TDI7_OUT(tdi7), .FUSE_BLOWN_IN(fuse),
    .DEBUG_ACCESS_EN_OUT(dbg_en), .TEST_BYPASS_OUT(bypass));
  ppfm_pad_model pads (.p1_drv_in(p1_out), .p1_oe_in(p1_oe), .p1_ext_in(p1_ext),
    .p2_drv_in(p2_out), .p2_oe_in(p2_oe), .p2_ext_in(p2_ext),
    .p1_pad_out(p1_in), .p2_pad_out(p2_in));
  // verdict and end of run, shared by the main sequence and the watchdog
  task automatic close_out();
    if (fail_count == 0 && total_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  // one comparison, counted; case inequality so unknowns never match
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      fail_count++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // one avalon access: hold until waitrequest is sampled low, take data at that edge
  task automatic bus(input logic w, input logic [5:0] a, input logic [7:0] d,
    output logic [31:0] q);
    int n;
    n = 0;
    @(posedge clk);
    rd <= ~w;
    wr <= w;
    addr <= a;
    wdata <= {24'h0, d};
    do
    begin
      @(posedge clk);
      n++;
    end
    while (waitreq !== 1'b0 && n < 50);
    q = rdata;
    rd <= 1'b0;
    wr <= 1'b0;
    if (n >= 50)
      chk(32'h1, 32'h0);
  endtask
  task automatic wrt(input logic [5:0] a, input logic [7:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask
  task automatic rdc(input logic [5:0] a, input logic [31:0] exp);
    logic [31:0] q;
    bus(1'b0, a, 8'h00, q);
    chk(q, exp);
  endtask
  // let config reach the pins (1 edge) or pad levels reach outputs (3 edges)
  task automatic settle(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  // expected port one outputs with every pin on its alternate output
  function automatic logic [7:0] alt_out(input logic c, input logic s, input logic [2:0] t);
    return {t[2], t[1], t[0], s, t[2], t[1], t[0], c};
  endfunction
  // power-on state: all pins gpio inputs, debug open, registers zero
  task automatic t_reset();
    chk(32'(p1_oe), 32'h0);
    chk(32'({p2_oe, p2_sch, p2_ana}), 32'h0c);
    chk(32'({dbg_en, bypass}), 32'h2);
    rdc(`PPFM_OFS_P1_SEL, 32'h0);
    rdc(`PPFM_OFS_STATUS, 32'h0);
    rdc(6'h3c, 32'h0); // unmapped address reads zero
  endtask
  // gpio: output bits drive the enabled pins, every pad readable back
  task automatic t_gpio();
    @(posedge clk);
    p1_ext <= 8'hc3;
    wrt(`PPFM_OFS_P1_OUT, 8'ha5);
    wrt(`PPFM_OFS_P1_DIR, 8'h0f);
    settle(4);
    chk(32'(p1_oe), 32'h0f);
    chk(32'(p1_out & 8'h0f), 32'h05);
    rdc(`PPFM_OFS_P1_IN, 32'hc5);
    wrt(`PPFM_OFS_P1_IN, 8'h00); // read-only place, write ignored
    rdc(`PPFM_OFS_P1_IN, 32'hc5);
  endtask
  // alternate functions of port one, outputs and inputs
  task automatic t_alt();
    wrt(`PPFM_OFS_P1_SEL, 8'hff);
    wrt(`PPFM_OFS_P1_DIR, 8'hff);
    for (int i = 0; i < 2; i++)
    begin
      @(posedge clk);
      {conv, sub, cmp} <= (i == 0) ? 5'b10101 : 5'b01010;
      settle(3);
      chk(32'(p1_oe), 32'hff);
      chk(32'(p1_out), 32'(alt_out(i == 0, i != 0, (i == 0) ? 3'b101 : 3'b010)));
    end
    @(posedge clk);
    p1_ext <= 8'h0b;
    wrt(`PPFM_OFS_P1_DIR, 8'h00);
    settle(4);
    chk(32'(p1_oe), 32'h0);
    chk(32'({ext_clk, cap_a}), 32'hd);
  endtask
  // port two alternate functions and analog override
  task automatic t_port_two();
    @(posedge clk);
    {aux, cmp} <= 4'b1001;
    p2_ext <= 2'b10;
    wrt(`PPFM_OFS_P2_SEL, 8'h05);
    wrt(`PPFM_OFS_P2_DIR, 8'h05);
    settle(3);
    chk(32'({p2_oe, p2_out}), 32'hf);
    wrt(`PPFM_OFS_P2_DIR, 8'h01);
    settle(4);
    chk(32'({p2_oe, cap_b}), 32'h3);
    wrt(`PPFM_OFS_ANALOG, 8'h05);
    settle(3);
    chk(32'({p2_oe, p2_sch, p2_ana}), 32'h03);
    rdc(`PPFM_OFS_P2_IN, 32'h0);
  endtask
  // 4-wire test mode takes pins 4..7 away from the port bits
  task automatic t_test_mode();
    @(posedge clk);
    p1_ext <= 8'h50;
    test <= 1'b1;
    wrt(`PPFM_OFS_P1_DIR, 8'hff);
    repeat (200) @(posedge clk);
    settle(4);
    chk(32'(p1_oe), 32'h0f);
    chk(32'({tck, tms, tdi, tdi7}), 32'ha);
    rdc(`PPFM_OFS_STATUS, 32'h1);
    @(posedge clk);
    {tdo, tdo_oe} <= 2'b11;
    settle(3);
    chk(32'({p1_oe[7], p1_out[7]}), 32'h3);
  endtask
  // blown fuse closes debug access and leaves bypass on for good
  task automatic t_fuse();
    @(posedge clk);
    fuse <= 1'b1;
    settle(4);
    chk(32'({dbg_en, bypass, tck, tms, tdi}), 32'h08);
    chk(32'(p1_oe), 32'hff);
    @(posedge clk);
    fuse <= 1'b0;
    settle(6);
    chk(32'({dbg_en, bypass}), 32'h1);
    rdc(`PPFM_OFS_STATUS, 32'h2);
  endtask
  // synchronous power-up clear returns every pin to gpio input outside test mode
  task automatic t_clear();
    @(posedge clk);
    power_up_clear <= 1'b1;
    @(posedge clk);
    power_up_clear <= 1'b0;
    settle(2);
    chk(32'({p1_oe, p2_oe, p2_sch}), 32'h003);
    rdc(`PPFM_OFS_P1_DIR, 32'h0);
    rdc(`PPFM_OFS_ANALOG, 32'h0);
  endtask
  // watchdog: the whole run needs well under 20000 cycles
  initial
  begin
    repeat (20000) @(posedge clk);
    fail_count++;
    close_out();
  end
  // main sequence
  initial
  begin
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    settle(2);
    t_reset();
    t_gpio();
    t_alt();
    t_port_two();
    t_test_mode();
    t_fuse();
    t_clear();
    close_out();
  end
endmodule
